// file: ecs_map.vh
/*
  Register map, field positions, reset values and bus codes of the encoder
  status and capture timing block.
  Assumes a 32-bit AHB-Lite bus with word-aligned single transfers.
*/
// Summary of operation
// - Every index event records direction in bit 4.
// - Timer overflow sets sticky bit 3, write-one clears.
// - Direction change between captures sets sticky bit 2.
// - First index pulse sets sticky bit 1.
// - Bit 0 shows error of latest index event.
// - Sixteen-bit capture timer is the time base.
// - Period register holds count between unit events.
// - Timer latch on timeout or position read.
// - Period latch on timeout or position read.
// - Direction at first index kept in bit 6.
`ifndef ECS_MAP_VH
`define ECS_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ECS_STATUS_OFF     12'h000
`define ECS_TIMEBASE_OFF   12'h004
`define ECS_PERIOD_OFF     12'h008
`define ECS_TB_LATCH_OFF   12'h00C
`define ECS_PRD_LATCH_OFF  12'h010
`define ECS_INT_STAT_OFF   12'h014
`define ECS_INT_EN_OFF     12'h018
`define ECS_INT_CLR_OFF    12'h01C

// ----------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------
`define ECS_POS_ERR_BIT    0
`define ECS_FIRST_IDX_BIT  1
`define ECS_CAP_DIR_BIT    2
`define ECS_CAP_OVF_BIT    3
`define ECS_IDX_DIR_BIT    4
`define ECS_FIRST_DIR_BIT  6

// ----------------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------------
`define ECS_IRQ_OVF_BIT    0
`define ECS_IRQ_DIR_BIT    1
`define ECS_IRQ_IDX_BIT    2
`define ECS_IRQ_UNIT_BIT   3
`define ECS_IRQ_W          4

// ----------------------------------------------------------------------
// Reset values and bus codes
// ----------------------------------------------------------------------
`define ECS_RST16          16'h0000
`define ECS_RST_IRQ        4'h0
`define ECS_HTRANS_NONSEQ  2'h2
`define ECS_HSIZE_WORD     3'h2
`define ECS_TMR_MAX        16'hFFFF

`endif

// file: ecs_sync.v
/*
  Two-flop synchroniser for a group of single-bit pin inputs.
  Assumes the inputs are asynchronous levels to hclk.
*/
`timescale 1ns/1ps
module ecs_sync #(
  parameter W = 4
) (
  // Clock and reset.
  input  wire         hclk,
  input  wire         hresetn,
  // Data.
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;  // First stage, read only by the second stage.
  reg [W-1:0] sync_q;  // Second stage, safe for logic.

  // Both stages clear on reset to a constant.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // ecs_sync

// file: ecs_top.v
/*
  Encoder status flags and capture timing registers with an AHB-Lite slave.
  Assumes event inputs (index, unit position, unit timeout, position read,
  position error, direction) come from decoder pins or logic outside hclk
  domain, so they are synchronised and edges detected here.
*/
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "ecs_map.vh"
module ecs_top (
  // Clock and reset.
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave.
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Encoder events.
  input  wire        index_evt,
  input  wire        unit_pos_evt,
  input  wire        unit_timeout_evt,
  input  wire        pos_read_evt,
  input  wire        pos_err_in,
  input  wire        dir_fwd,
  input  wire        latch_on_read,
  input  wire        cap_tick,
  // Interrupt.
  output reg         irq
);

  // --------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------
  wire [7:0] s;       // Synchronised event and level inputs.
  reg  [4:0] prev_q;  // Previous values for edge detection.

  ecs_sync #(.W(8)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({cap_tick, latch_on_read, dir_fwd, pos_err_in, pos_read_evt,
                unit_timeout_evt, unit_pos_evt, index_evt}),
    .sync_out (s)
  );

  wire idx_p  = s[0] & ~prev_q[0];  // Index rising edge.
  wire unit_p = s[1] & ~prev_q[1];  // Unit position rising edge.
  wire uto_p  = s[2] & ~prev_q[2];  // Unit timeout rising edge.
  wire rd_p   = s[3] & ~prev_q[3];  // Position counter read edge.
  wire tick_p = s[7] & ~prev_q[4];  // Capture prescaler tick edge.
  wire perr   = s[4];
  wire dir    = s[5];
  wire selrd  = s[6];

  // --------------------------------------------------------------------
  // Bus address phase capture
  // --------------------------------------------------------------------
  reg        wr_q;    // Data phase is a write.
  reg [11:0] addr_q;  // Latched address.

  // Only whole-word transfers are taken; a narrower size is ignored.
  wire take = hsel & hready & (htrans == `ECS_HTRANS_NONSEQ) & (hsize == `ECS_HSIZE_WORD);
  wire wr_en = wr_q;

  // Returns one when a write targets the given offset.
  function wr_hit;
    input [11:0] off;
    begin
      wr_hit = wr_en & (addr_q == off);
    end
  endfunction

  // --------------------------------------------------------------------
  // Status and timing storage
  // --------------------------------------------------------------------
  reg        idx_dir_q;    // Direction at last index event.
  reg        ovf_q;        // Sticky capture overflow.
  reg        cap_dir_q;    // Sticky direction change.
  reg        first_q;      // Sticky first index seen.
  reg        perr_q;       // Error at last index event.
  reg        first_dir_q;  // Direction at first index.
  reg        seen_q;       // First index ever seen since reset.
  reg        cap_last_dir_q;  // Direction at previous unit event.
  reg        unit_seen_q;     // A unit event has been seen since reset.
  reg [15:0] tmr_q;        // Capture timer.
  reg [15:0] prd_q;        // Capture period.
  reg [15:0] tb_lat_q;     // Timer latch.
  reg [15:0] prd_lat_q;    // Period latch.
  reg [3:0]  ist_q;        // Interrupt status.
  reg [3:0]  ien_q;        // Interrupt enable.

  wire [15:0] wd = hwdata[15:0];
  wire ovf_evt = tick_p & (tmr_q == `ECS_TMR_MAX);
  // The first unit event has no predecessor, so it can flag no change.
  wire dir_evt = unit_p & unit_seen_q & (dir != cap_last_dir_q);
  wire first_evt = idx_p & ~seen_q;
  wire lat_evt = selrd ? rd_p : uto_p;

  // Status flags; a hardware set wins over a software clear in one cycle.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_dir_q      <= 1'b0;
      ovf_q          <= 1'b0;
      cap_dir_q      <= 1'b0;
      first_q        <= 1'b0;
      perr_q         <= 1'b0;
      first_dir_q    <= 1'b0;
      seen_q         <= 1'b0;
      cap_last_dir_q <= 1'b0;
      unit_seen_q    <= 1'b0;
      prev_q         <= 5'h00;
    end else begin
      prev_q <= {s[7], s[3:0]};
      if (idx_p) begin
        idx_dir_q <= dir;
        perr_q    <= perr;
        seen_q    <= 1'b1;
      end
      if (first_evt) begin
        first_dir_q <= dir;
      end
      if (unit_p) begin
        cap_last_dir_q <= dir;
        unit_seen_q    <= 1'b1;
      end
      if (ovf_evt) begin
        ovf_q <= 1'b1;
      end else if (wr_hit(`ECS_STATUS_OFF) && hwdata[`ECS_CAP_OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
      if (dir_evt) begin
        cap_dir_q <= 1'b1;
      end else if (wr_hit(`ECS_STATUS_OFF) && hwdata[`ECS_CAP_DIR_BIT]) begin
        cap_dir_q <= 1'b0;
      end
      if (first_evt) begin
        first_q <= 1'b1;
      end else if (wr_hit(`ECS_STATUS_OFF) && hwdata[`ECS_FIRST_IDX_BIT]) begin
        first_q <= 1'b0;
      end
    end
  end

  // Capture timer, period and latch registers; writable by software.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_q     <= `ECS_RST16;
      prd_q     <= `ECS_RST16;
      tb_lat_q  <= `ECS_RST16;
      prd_lat_q <= `ECS_RST16;
    end else begin
      if (unit_p) begin
        tmr_q <= `ECS_RST16;
      end else if (wr_hit(`ECS_TIMEBASE_OFF)) begin
        tmr_q <= wd;
      end else if (tick_p) begin
        tmr_q <= tmr_q + 16'h0001;
      end
      if (unit_p) begin
        prd_q <= tmr_q;
      end else if (wr_hit(`ECS_PERIOD_OFF)) begin
        prd_q <= wd;
      end
      if (lat_evt) begin
        tb_lat_q <= tmr_q;
      end else if (wr_hit(`ECS_TB_LATCH_OFF)) begin
        tb_lat_q <= wd;
      end
      if (lat_evt) begin
        prd_lat_q <= prd_q;
      end else if (wr_hit(`ECS_PRD_LATCH_OFF)) begin
        prd_lat_q <= wd;
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status, enable and clear
  // --------------------------------------------------------------------
  wire [3:0] irq_set = {unit_p, idx_p, dir_evt, ovf_evt};
  wire [3:0] irq_clr = wr_hit(`ECS_INT_CLR_OFF) ? hwdata[3:0] : 4'h0;

  // Set beats clear so no event is lost in a clearing cycle.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_q <= `ECS_RST_IRQ;
      ien_q <= `ECS_RST_IRQ;
      irq   <= 1'b0;
    end else begin
      ist_q <= irq_set | (ist_q & ~irq_clr);
      if (wr_hit(`ECS_INT_EN_OFF)) begin
        ien_q <= hwdata[3:0];
      end
      irq <= |((irq_set | (ist_q & ~irq_clr)) & (wr_hit(`ECS_INT_EN_OFF) ?
                                                  hwdata[3:0] : ien_q));
    end
  end

  // --------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // --------------------------------------------------------------------
  wire [15:0] status = {9'h000, first_dir_q, 1'b0, idx_dir_q, ovf_q,
                        cap_dir_q, first_q, perr_q};

  // Read mux; unmapped and write-only offsets read zero.
  reg [31:0] rmux;
  always @* begin
    rmux = 32'h0000_0000;
    case (haddr)
      `ECS_STATUS_OFF:    rmux = {16'h0000, status};
      `ECS_TIMEBASE_OFF:  rmux = {16'h0000, tmr_q};
      `ECS_PERIOD_OFF:    rmux = {16'h0000, prd_q};
      `ECS_TB_LATCH_OFF:  rmux = {16'h0000, tb_lat_q};
      `ECS_PRD_LATCH_OFF: rmux = {16'h0000, prd_lat_q};
      `ECS_INT_STAT_OFF:  rmux = {28'h0000000, ist_q};
      `ECS_INT_EN_OFF:    rmux = {28'h0000000, ien_q};
      default:            rmux = 32'h0000_0000;
    endcase
  end

  // Address phase capture; read data is loaded at the address edge so it
  // stands through the data phase (reflects state of that edge).
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      addr_q    <= 12'h000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_q      <= take & hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (take) begin
        addr_q <= {haddr[11:2], 2'b00};
      end
      if (take && !hwrite) begin
        hrdata <= rmux;
      end
    end
  end

endmodule // ecs_top

// file: ecs_top_asserts.sv
/* Bus and flag checks for the encoder status block.
   Assumes it is bound to ecs_top and sees its ports only. */
`timescale 1ns/1ps
`include "ecs_map.vh"
module ecs_top_asserts (
  // Clock and reset.
  input wire        hclk,
  input wire        hresetn,
  // Bus and interrupt.
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        irq
);
  // Address phases taken at this edge.
  wire rd_t = hsel && hready && htrans == 2'h2 && !hwrite;
  wire wr_t = hsel && hready && htrans == 2'h2 && hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ready_kept: assert property (hreadyout) else $error("ready low");
  chk_resp_okay: assert property (!hresp) else $error("error response");
  chk_rdata_hold: assert property (!$past(rd_t) |-> $stable(hrdata))
    else $error("read data moved");
  chk_upper_zero: assert property (rd_t |=> hrdata[31:16] == 16'h0)
    else $error("upper half set");
  chk_unmapped_zero: assert property (rd_t && haddr >= 12'h020 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_status_spare: assert property (rd_t && haddr == `ECS_STATUS_OFF
    |=> hrdata[15:7] == 9'h0 && !hrdata[5]) else $error("status spare set");
  chk_istat_width: assert property (rd_t && haddr == `ECS_INT_STAT_OFF
    |=> hrdata[31:4] == 28'h0) else $error("int status too wide");
  chk_irq_masked: assert property (wr_t && haddr == `ECS_INT_EN_OFF
    ##1 hwdata[3:0] == 4'h0 |-> ##[1:2] !irq) else $error("irq not masked");
endmodule // ecs_top_asserts
bind ecs_top ecs_top_asserts ecs_top_asserts_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

// file: ecs_enc_model.sv
/* Encoder partner: event lines and direction and error levels.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module ecs_enc_model (
  // Clock.
  input  wire  hclk,
  // Event lines.
  output wire  index_evt,
  output wire  unit_pos_evt,
  output wire  unit_timeout_evt,
  output wire  pos_read_evt,
  output wire  cap_tick,
  // Levels.
  output logic pos_err_in,
  output logic dir_fwd
);
  logic [4:0] ev = 5'h0;  // Index, unit, timeout, read, tick.
  assign {cap_tick, pos_read_evt, unit_timeout_evt, unit_pos_evt, index_evt} = ev;
  initial begin
    pos_err_in = 1'b0;
    dir_fwd = 1'b0;
  end
  // Three cycles high and four low, so the synchronised edge has landed.
  task automatic pulse(input int k);
    @(posedge hclk);
    // Only the chosen line moves; the others keep their level.
    ev <= ev | (5'h01 << k);
    repeat (3) @(posedge hclk);
    ev <= ev & ~(5'h01 << k);
    repeat (4) @(posedge hclk);
  endtask
  // Levels settle well before the next event edge.
  task automatic level(input logic d, input logic e);
    @(posedge hclk);
    dir_fwd <= d;
    pos_err_in <= e;
  endtask
endmodule // ecs_enc_model

// file: ecs_top_tb.sv
/* Self-checking bench for ecs_top.
   Assumes the model and the bound checker are compiled first. */
`timescale 1ns/1ps
`include "ecs_map.vh"
module ecs_top_tb;
  logic        hclk, hresetn, hsel, hwrite, dph, lat_rd;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, rs, r;
  logic [43:0] e, exp_q[$];  // Pending reads: address and expected word.
  logic [15:0] v, n;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, irq, idx, upe, uto, prd, perr, dfw, tick;
  int          n_fail = 0, check_count = 0, cyc = 0;
  ecs_top ecs_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .index_evt(idx),
    .unit_pos_evt(upe), .unit_timeout_evt(uto), .pos_read_evt(prd), .pos_err_in(perr),
    .dir_fwd(dfw), .latch_on_read(lat_rd), .cap_tick(tick), .irq(irq));
  ecs_enc_model ecs_enc_model_i (.hclk(hclk), .index_evt(idx), .unit_pos_evt(upe),
    .unit_timeout_evt(uto), .pos_read_evt(prd), .cap_tick(tick), .pos_err_in(perr),
    .dir_fwd(dfw));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input logic [11:0] a, input logic [31:0] x, input logic [31:0] s);
    check_count++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] reg 0x%h expected %h seen %h", a, x, s);
    end
  endtask
  // One single word transfer; a read notes its expectation first.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back({a, d});
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= `ECS_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    // Select and size wander between transfers; without NONSEQ they are ignored.
    hsel <= 1'(rnd());
    hsize <= 3'(rnd());
    htrans <= 2'h0;
    hwdata <= w ? d : rnd();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic irqk(input logic x);
    repeat (3) @(posedge hclk);
    chk(12'hFFF, {31'h0, x}, {31'h0, irq});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Read data is due at the data edge; the oldest note is compared.
  always @(posedge hclk) begin
    if (dph) begin
      e = exp_q.pop_front();
      chk(e[43:32], e[31:0], hrdata);
    end
    dph <= hsel && hreadyout && htrans == 2'h2 && !hwrite;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, hsize, haddr, htrans, hwdata} = '0;
    lat_rd = 1'b1;
    rs = 32'h04F585E5;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 9; i++) if (i != 7) xfer(0, 12'(i * 4), 0);
    $display("reset values done");
    r = rnd();
    ecs_enc_model_i.level(1, r[0]);
    ecs_enc_model_i.pulse(0);
    xfer(0, `ECS_STATUS_OFF, 32'h52 | 32'(r[0]));
    ecs_enc_model_i.level(0, r[1]);
    ecs_enc_model_i.pulse(0);
    xfer(0, `ECS_STATUS_OFF, 32'h42 | 32'(r[1]));
    xfer(1, `ECS_STATUS_OFF, 32'h2);
    xfer(0, `ECS_STATUS_OFF, 32'h40 | 32'(r[1]));
    ecs_enc_model_i.level(0, 0);
    ecs_enc_model_i.pulse(0);
    xfer(0, `ECS_STATUS_OFF, 32'h40);
    $display("index flags done");
    v = 16'(rnd()) & 16'h7FFF;
    n = 16'(3 + rnd() % 8);
    xfer(1, `ECS_TIMEBASE_OFF, 32'(v));
    repeat (n) ecs_enc_model_i.pulse(4);
    xfer(0, `ECS_TIMEBASE_OFF, 32'(v + n));
    ecs_enc_model_i.pulse(1);
    xfer(0, `ECS_PERIOD_OFF, 32'(v + n));
    xfer(0, `ECS_TIMEBASE_OFF, 0);
    repeat (2) ecs_enc_model_i.pulse(4);
    ecs_enc_model_i.pulse(3);
    xfer(0, `ECS_TB_LATCH_OFF, 2);
    xfer(0, `ECS_PRD_LATCH_OFF, 32'(v + n));
    lat_rd <= ~lat_rd;
    ecs_enc_model_i.pulse(4);
    ecs_enc_model_i.pulse(3);
    xfer(0, `ECS_TB_LATCH_OFF, 2);
    ecs_enc_model_i.pulse(2);
    xfer(0, `ECS_TB_LATCH_OFF, 3);
    xfer(0, `ECS_PRD_LATCH_OFF, 32'(v + n));
    $display("timer and latches done");
    ecs_enc_model_i.pulse(1);
    xfer(0, `ECS_STATUS_OFF, 32'h40);
    ecs_enc_model_i.level(!dfw, r[2]);
    ecs_enc_model_i.pulse(1);
    xfer(0, `ECS_STATUS_OFF, 32'h44);
    xfer(1, `ECS_STATUS_OFF, 32'h4);
    xfer(0, `ECS_STATUS_OFF, 32'h40);
    $display("direction change done");
    xfer(1, `ECS_INT_CLR_OFF, 32'hF);
    xfer(1, `ECS_INT_EN_OFF, 32'h1);
    irqk(0);
    xfer(1, `ECS_TIMEBASE_OFF, 32'hFFFF);
    ecs_enc_model_i.pulse(4);
    xfer(0, `ECS_STATUS_OFF, 32'h48);
    xfer(0, `ECS_INT_STAT_OFF, 32'h1);
    irqk(1);
    xfer(1, `ECS_INT_EN_OFF, 32'h0);
    irqk(0);
    xfer(1, `ECS_INT_EN_OFF, 32'h1);
    irqk(1);
    xfer(1, `ECS_INT_CLR_OFF, 32'h1);
    irqk(0);
    xfer(1, `ECS_STATUS_OFF, 32'h8);
    xfer(0, `ECS_STATUS_OFF, 32'h40);
    $display("overflow and interrupt done");
    repeat (2) @(posedge hclk);
    final_report();
  end
endmodule // ecs_top_tb
